// ===== shared/ncr_pkg.sv
package ncr_pkg;

  // Command bytes
  localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
  localparam logic [7:0] CMD_READ_GO     = 8'h30;
  localparam logic [7:0] CMD_COPY_GO     = 8'h3A;
  localparam logic [7:0] CMD_COLR        = 8'h05;
  localparam logic [7:0] CMD_COLR_GO     = 8'hE0;
  localparam logic [7:0] CMD_CACHE       = 8'h31;
  localparam logic [7:0] CMD_CACHE_END   = 8'h3F;
  localparam logic [7:0] CMD_LOAD        = 8'h80;
  localparam logic [7:0] CMD_PLANE_LOAD  = 8'h81;
  localparam logic [7:0] CMD_COPY_LOAD   = 8'h8C;
  localparam logic [7:0] CMD_COLW        = 8'h85;
  localparam logic [7:0] CMD_PROG        = 8'h10;
  localparam logic [7:0] CMD_PROG_CACHE  = 8'h15;
  localparam logic [7:0] CMD_PLANE_NEXT  = 8'h11;
  localparam logic [7:0] CMD_ERASE       = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO    = 8'hD0;
  localparam logic [7:0] CMD_ID          = 8'h90;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_STATUS_MP   = 8'h71;
  localparam logic [7:0] CMD_RESET       = 8'hFF;

  // Address layout
  localparam int         COL_W       = 13;
  localparam int         ROW_W       = 18;
  localparam int         PAGE_W      = 6;
  localparam int         BLK_LSB     = 6;
  localparam int         HALF_BIT    = 17;
  localparam logic [2:0] AI_COL0     = 3'h0;
  localparam logic [2:0] AI_ROW0     = 3'h2;
  localparam logic [2:0] AI_COL_END  = 3'h2;
  localparam logic [2:0] AI_ID_END   = 3'h1;
  localparam logic [2:0] AI_END      = 3'h5;
  localparam logic [2:0] AI_LAST     = 3'h4;

  // Timing
  localparam int CLK_MHZ  = 10;
  localparam int T_WB_NS  = 100;
  localparam int WB_CYC   = ((T_WB_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
                            (T_WB_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [4:0] {
    OP_READ, OP_READ_PWRUP, OP_READ_COPY, OP_COL_RD, OP_CACHE_RD, OP_CACHE_LAST,
    OP_PLANE_SEL, OP_PLANE_GO, OP_PROG_LOAD, OP_PLANE_LOAD, OP_COPY_LOAD, OP_PROG_COL,
    OP_CONF_PROG, OP_CONF_CACHE, OP_CONF_PLANE, OP_ERASE, OP_ID, OP_STATUS,
    OP_STATUS_MP, OP_RESET
  } ncr_op_e;

  typedef struct packed {
    logic       has_c1;
    logic [7:0] c1;
    logic [2:0] a_first;
    logic [2:0] a_end;
    logic       wr;
    logic       has_c2;
    logic [7:0] c2;
    logic       busy;
    logic       rd;
    logic       prot;
  } ncr_dec_s;

  function automatic ncr_dec_s ncr_mk(int h1, logic [7:0] c1, logic [2:0] af,
                                      logic [2:0] ae, int wr, int h2, logic [7:0] c2,
                                      int bsy, int rd, int prot);
    ncr_mk = '{1'(h1), c1, af, ae, 1'(wr), 1'(h2), c2, 1'(bsy), 1'(rd), 1'(prot)};
  endfunction

  function automatic ncr_dec_s ncr_decode(ncr_op_e op);
    unique case (op)
      OP_READ:       ncr_decode = ncr_mk(1, CMD_READ_SETUP, AI_COL0, AI_END, 0, 1, CMD_READ_GO,
                                         1, 1, 0);
      OP_READ_PWRUP: ncr_decode = ncr_mk(0, CMD_READ_SETUP, AI_COL0, AI_END, 0, 1, CMD_READ_GO,
                                         1, 1, 0);
      OP_READ_COPY:  ncr_decode = ncr_mk(1, CMD_READ_SETUP, AI_COL0, AI_END, 0, 1, CMD_COPY_GO,
                                         1, 1, 0);
      OP_COL_RD:     ncr_decode = ncr_mk(1, CMD_COLR, AI_COL0, AI_COL_END, 0, 1, CMD_COLR_GO,
                                         0, 1, 0);
      OP_CACHE_RD:   ncr_decode = ncr_mk(1, CMD_CACHE, AI_END, AI_END, 0, 0, 8'h00, 1, 1, 0);
      OP_CACHE_LAST: ncr_decode = ncr_mk(1, CMD_CACHE_END, AI_END, AI_END, 0, 0, 8'h00, 1, 1, 0);
      OP_PLANE_SEL:  ncr_decode = ncr_mk(1, CMD_ERASE, AI_ROW0, AI_END, 0, 0, 8'h00, 0, 0, 0);
      OP_PLANE_GO:   ncr_decode = ncr_mk(1, CMD_READ_GO, AI_END, AI_END, 0, 0, 8'h00, 1, 1, 0);
      OP_PROG_LOAD:  ncr_decode = ncr_mk(1, CMD_LOAD, AI_COL0, AI_END, 1, 0, 8'h00, 0, 0, 1);
      OP_PLANE_LOAD: ncr_decode = ncr_mk(1, CMD_PLANE_LOAD, AI_COL0, AI_END, 1, 0, 8'h00,
                                         0, 0, 1);
      OP_COPY_LOAD:  ncr_decode = ncr_mk(1, CMD_COPY_LOAD, AI_COL0, AI_END, 1, 0, 8'h00, 0, 0, 1);
      OP_PROG_COL:   ncr_decode = ncr_mk(1, CMD_COLW, AI_COL0, AI_COL_END, 1, 0, 8'h00, 0, 0, 1);
      OP_CONF_PROG:  ncr_decode = ncr_mk(1, CMD_PROG, AI_END, AI_END, 0, 0, 8'h00, 1, 0, 1);
      OP_CONF_CACHE: ncr_decode = ncr_mk(1, CMD_PROG_CACHE, AI_END, AI_END, 0, 0, 8'h00, 1, 0, 1);
      OP_CONF_PLANE: ncr_decode = ncr_mk(1, CMD_PLANE_NEXT, AI_END, AI_END, 0, 0, 8'h00, 1, 0, 1);
      OP_ERASE:      ncr_decode = ncr_mk(1, CMD_ERASE, AI_ROW0, AI_END, 0, 1, CMD_ERASE_GO,
                                         1, 0, 1);
      OP_ID:         ncr_decode = ncr_mk(1, CMD_ID, AI_COL0, AI_ID_END, 0, 0, 8'h00, 0, 1, 0);
      OP_STATUS:     ncr_decode = ncr_mk(1, CMD_STATUS, AI_END, AI_END, 0, 0, 8'h00, 0, 1, 0);
      OP_STATUS_MP:  ncr_decode = ncr_mk(1, CMD_STATUS_MP, AI_END, AI_END, 0, 0, 8'h00, 0, 1, 0);
      OP_RESET:      ncr_decode = ncr_mk(1, CMD_RESET, AI_END, AI_END, 0, 0, 8'h00, 1, 0, 0);
      default:       ncr_decode = ncr_mk(1, CMD_STATUS, AI_END, AI_END, 0, 0, 8'h00, 0, 1, 0);
    endcase
  endfunction

endpackage

// ===== verilog/ncr_host.sv
// Contract
// - CLE marks command, ALE address, neither data; latch on strobe rise.
// - Host holds write and output strobes high while device is busy.
// - Page read is setup byte, five address bytes, confirm byte.
// - Host refuses cached reads off the last read's block, and after the last cached read, a program or a reset until a normal read restarts them.
// - Host picks one block per plane, same page bits, own prefix each.
// - Host keeps program lock high during two-plane read; lock still follows prog_unlock in the cycle the first select is taken.
// - Address is two column then three row bytes, upper bits low.
`timescale 1ns/100ps
module ncr_host #(
  parameter int FIFO_DEPTH = 2,
  parameter int DATA_W     = 8,
  parameter int LEN_W      = 13
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // User command port
  input  wire logic                  cmd_valid,
  input  wire ncr_pkg::ncr_op_e      cmd_op,
  input  wire logic [ncr_pkg::COL_W-1:0] cmd_col,
  input  wire logic [ncr_pkg::ROW_W-1:0] cmd_row,
  input  wire logic [LEN_W-1:0]      cmd_len,
  input  wire logic                  prog_unlock,
  output logic                       cmd_ready,
  output logic                       cmd_done,
  output logic                       cmd_err,
  // Program data in
  input  wire logic                  wr_valid,
  input  wire logic [DATA_W-1:0]     wr_data,
  output logic                       wr_ready,
  // Read data out
  output logic                       rd_valid,
  output logic [DATA_W-1:0]          rd_data,
  input  wire logic                  rd_ready,
  // Flash pins
  output logic                       command_latch_enable,
  output logic                       address_latch_strobe,
  output logic                       chip_select_n,
  output logic                       write_strobe_n,
  output logic                       output_strobe_n,
  output logic                       program_lock_n,
  output logic [DATA_W-1:0]          io_out,
  output logic                       io_oe,
  input  wire logic [DATA_W-1:0]     io_in,
  input  wire logic                  ready_busy_n
);
  import ncr_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH + 1);

  typedef enum logic [3:0] {
    S_IDLE, S_START, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WB, S_BUSY, S_RDATA
  } ncr_state_e;

  ncr_state_e        state, next_state;
  logic              ph, next_ph;
  ncr_dec_s          dec;
  logic [COL_W-1:0]  col;
  logic [ROW_W-1:0]  row;
  logic [LEN_W-1:0]  len, next_len;
  logic [2:0]        acnt, next_acnt;
  logic [3:0]        wbcnt;
  logic [DATA_W-1:0] next_obyte;
  logic [1:0]        plane_cnt;
  logic [ROW_W-1:0]  plane_row;
  logic              cache_on;
  logic [11:0]       cache_blk;
  logic              push;

  ////////////////////////////////////////////////////////////////////////
  // Request decode and host-side checks
  ncr_dec_s   req;
  wire        take      = cmd_valid && cmd_ready;
  wire [11:0] req_blk   = cmd_row[ROW_W-1:BLK_LSB];
  wire        is_cache  = (cmd_op == OP_CACHE_RD) || (cmd_op == OP_CACHE_LAST);
  wire        plane_bad = (plane_cnt == 2'h2) || ((plane_cnt == 2'h1) &&
                          ((cmd_row[PAGE_W-1:0] != plane_row[PAGE_W-1:0]) ||
                           (cmd_row[BLK_LSB] == plane_row[BLK_LSB]) ||
                           (cmd_row[HALF_BIT] != plane_row[HALF_BIT])));
  wire        refuse    = (req.prot && !program_lock_n) ||
                          ((cmd_op == OP_PLANE_SEL) && (plane_bad || !program_lock_n)) ||
                          ((cmd_op == OP_PLANE_GO) && (plane_cnt != 2'h2)) ||
                          (is_cache && (!cache_on || (req_blk != cache_blk)));
  wire        go        = take && !refuse;
  wire        wr_take   = wr_valid && wr_ready;
  assign req = ncr_decode(cmd_op);

  // Two column bytes, three row bytes, unused bits low
  wire [39:0] avec = {6'h00, row[17:16], row[15:8], row[7:0],
                      3'h0, col[12:8], col[7:0]};
  wire [DATA_W-1:0] abyte = avec[{next_acnt, 3'h0} +: 8];

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  wire [CW-1:0] fcnt_w;
  wire          fifo_space = fcnt_w < CW'(FIFO_DEPTH);
  ncr_state_e   after_busy, after_cmd2, after_data, after_addr, after_cmd1;
  assign after_busy = (dec.rd && (len != '0)) ? S_RDATA : S_IDLE;
  assign after_cmd2 = dec.busy ? S_WB : after_busy;
  assign after_data = dec.has_c2 ? S_CMD2 : after_cmd2;
  assign after_addr = (dec.wr && (len != '0)) ? S_WDATA : after_data;
  assign after_cmd1 = (acnt != dec.a_end) ? S_ADDR : after_addr;

  always_comb begin
    next_state = state;
    next_ph    = ph;
    next_len   = len;
    next_acnt  = acnt;
    push       = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (go) begin
          next_state = S_START;
          next_len   = cmd_len;
          next_acnt  = req.a_first;
        end
      end
      S_START: begin
        next_ph    = 1'b0;
        next_state = dec.has_c1 ? S_CMD1 : S_ADDR;
      end
      S_CMD1, S_CMD2: begin
        next_ph = !ph;
        if (ph) begin
          next_state = (state == S_CMD1) ? after_cmd1 : after_cmd2;
          // Reads open with the strobe high, so the room check runs first
          next_ph    = next_state == S_RDATA;
        end
      end
      S_ADDR: begin
        next_ph = !ph;
        if (ph) begin
          next_acnt = acnt + 3'h1;
          if (acnt + 3'h1 == dec.a_end) begin
            next_state = after_addr;
            next_ph    = after_addr == S_RDATA;
          end
        end
      end
      S_WDATA: begin
        if (ph) begin
          next_ph = 1'b0;
        end else if (len == '0) begin
          next_state = after_data;
        end else if (wr_take) begin
          next_ph  = 1'b1;
          next_len = len - 1'b1;
        end
      end
      S_WB: begin
        next_ph = 1'b1;
        if (wbcnt == 4'(WB_CYC - 1)) begin
          next_state = S_BUSY;
        end
      end
      S_BUSY: begin
        if (ready_busy_n) begin
          next_state = after_busy;
        end
      end
      S_RDATA: begin
        if (!ph) begin
          push     = 1'b1;
          next_len = len - 1'b1;
          next_ph  = 1'b1;
        end else if (len == '0) begin
          next_state = S_IDLE;
        end else if (fifo_space) begin
          next_ph = 1'b0;
        end
      end
    endcase
  end

  // Stall on a full buffer keeps the strobe high, so no byte is lost
  wire n_cmd   = (next_state == S_CMD1) || (next_state == S_CMD2);
  wire n_addr  = next_state == S_ADDR;
  wire n_wdat  = next_state == S_WDATA;
  wire n_we    = ((n_cmd || n_addr) && !next_ph) || (n_wdat && next_ph);
  wire n_rstb  = (next_state == S_RDATA) && !next_ph;
  assign next_obyte = (next_state == S_CMD1) ? dec.c1 :
                      (next_state == S_CMD2) ? dec.c2 :
                      n_addr ? abyte :
                      (n_wdat && wr_take) ? wr_data : io_out;

  always_ff @(posedge clk) begin
    if (rst) begin
      state                <= S_IDLE;
      ph                   <= 1'b0;
      len                  <= '0;
      acnt                 <= '0;
      wbcnt                <= '0;
      cmd_ready            <= 1'b0;
      cmd_done             <= 1'b0;
      cmd_err              <= 1'b0;
      wr_ready             <= 1'b0;
      command_latch_enable <= 1'b0;
      address_latch_strobe <= 1'b0;
      chip_select_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      output_strobe_n      <= 1'b1;
      io_out               <= '0;
      io_oe                <= 1'b0;
    end else begin
      state                <= next_state;
      ph                   <= next_ph;
      len                  <= next_len;
      acnt                 <= next_acnt;
      wbcnt                <= (state == S_WB) ? wbcnt + 4'h1 : 4'h0;
      cmd_ready            <= next_state == S_IDLE;
      cmd_done             <= (state != S_IDLE) && (next_state == S_IDLE);
      cmd_err              <= take && refuse;
      wr_ready             <= n_wdat && !next_ph && (next_len != '0);
      command_latch_enable <= n_cmd;
      address_latch_strobe <= n_addr;
      chip_select_n        <= next_state == S_IDLE;
      write_strobe_n       <= !n_we;
      output_strobe_n      <= !n_rstb;
      io_out               <= next_obyte;
      io_oe                <= n_cmd || n_addr || n_wdat;
    end
  end

  // Request context, plane pairing and cached-read tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      dec            <= '0;
      col            <= '0;
      row            <= '0;
      plane_cnt      <= 2'h0;
      plane_row      <= '0;
      cache_on       <= 1'b0;
      cache_blk      <= '0;
      program_lock_n <= 1'b0;
    end else begin
      if (state == S_IDLE && plane_cnt == 2'h0) begin
        program_lock_n <= prog_unlock;
      end
      if (go) begin
        dec <= req;
        col <= cmd_col;
        row <= cmd_row;
        if (cmd_op == OP_PLANE_SEL) begin
          plane_cnt <= plane_cnt + 2'h1;
          if (plane_cnt == 2'h0) begin
            plane_row <= cmd_row;
          end
        end
        if (cmd_op == OP_PLANE_GO) begin
          plane_cnt <= 2'h0;
        end
        if (cmd_op == OP_READ || cmd_op == OP_READ_PWRUP || cmd_op == OP_PLANE_GO) begin
          cache_on  <= 1'b1;
          cache_blk <= (cmd_op == OP_PLANE_GO) ? plane_row[ROW_W-1:BLK_LSB] : req_blk;
        end else if (cmd_op == OP_CACHE_LAST || req.prot || cmd_op == OP_RESET) begin
          cache_on <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read buffer: entry 0 is the output register
  logic [DATA_W-1:0] mem [FIFO_DEPTH];
  logic [CW-1:0]     fcnt;
  wire               pop = rd_valid && rd_ready;
  wire [CW-1:0]      next_fcnt = fcnt + CW'(push) - CW'(pop);
  assign fcnt_w  = fcnt;
  assign rd_data = mem[0];

  for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_ent
    wire [DATA_W-1:0] above;
    if (i == FIFO_DEPTH - 1) begin : g_top
      assign above = mem[i];
    end else begin : g_mid
      assign above = mem[i+1];
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        mem[i] <= '0;
      end else if (pop) begin
        mem[i] <= (push && (CW'(i) == fcnt - CW'(1))) ? io_in : above;
      end else if (push && (CW'(i) == fcnt)) begin
        mem[i] <= io_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fcnt     <= '0;
      rd_valid <= 1'b0;
    end else begin
      fcnt     <= next_fcnt;
      rd_valid <= next_fcnt != '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  we_pulse_a: assert property ($fell(write_strobe_n) |=> $rose(write_strobe_n) && io_oe)
    else $error("write strobe low not one cycle");
  busy_quiet_a: assert property (state == S_BUSY |-> write_strobe_n && output_strobe_n)
    else $error("strobe moved while busy");
  lock_refuse_a: assert property (take && req.prot && !program_lock_n |=> cmd_err && cmd_ready)
    else $error("program op not refused under lock");
  plane_pair_a: assert property (take && cmd_op == OP_PLANE_SEL && plane_cnt == 2'h1 &&
                                 cmd_row[5:0] != plane_row[5:0] |=> cmd_err)
    else $error("mismatched plane page accepted");
  cache_block_a: assert property (take && is_cache && cache_on && req_blk != cache_blk
                                  |=> cmd_err)
    else $error("cached read across block accepted");
  lock_hold_a: assert property (plane_cnt != 2'h0 |=> $stable(program_lock_n))
    else $error("lock changed during plane read");
  addr_top_a: assert property (address_latch_strobe && acnt == AI_LAST && !write_strobe_n
                               |-> io_out[7:2] == 6'h00)
    else $error("fifth address byte upper bits set");
  wait_ready_a: assert property (state == S_BUSY && !ready_busy_n |=> state == S_BUSY)
    else $error("left busy wait early");
  bus_turn_a: assert property (!output_strobe_n |-> !io_oe ##1 output_strobe_n)
    else $error("bus driven during read strobe");
  cmd_we_a: assert property (command_latch_enable && !write_strobe_n |=> command_latch_enable
                             && write_strobe_n && $stable(io_out))
    else $error("command byte not held across rise");

  read_done_c: cover property (state == S_RDATA && next_state == S_IDLE);
  prog_conf_c: cover property (take && cmd_op == OP_CONF_PROG && !refuse);
  plane_go_c: cover property (take && cmd_op == OP_PLANE_GO && !refuse);
  fifo_full_c: cover property (fcnt == CW'(FIFO_DEPTH) && state == S_RDATA);

endmodule

// ===== dv/ncr_flash_model.sv
`timescale 1ns/100ps
// Behavioural flash die, strobe-edge driven, no clock
module ncr_flash_model (
  // Control pins
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       rd_stb_n,
  input  wire logic       wp_n,
  // Data and status
  input  wire logic [7:0] io,
  output logic [7:0]      q,
  output logic            rb_n
);
  int          busy_ns = 2000, ai = 0, n00 = 0, n_ign = 0, progs = 0;
  logic        lock_err = 0;
  logic [7:0]  last_cmd = 0, cur = 0;
  logic [12:0] col = 0;
  logic [17:0] row = 0;
  logic [7:0]  wbuf[int];
  wire         busy = !rb_n;
  wire         fin  = io inside {8'h30, 8'h3A, 8'h31, 8'h3F, 8'h10, 8'h15, 8'h11, 8'hD0, 8'hFF};
  ////////////////////
  // Released bus shows the inverse, so a stale byte never passes
  assign q = (!ce_n && !rd_stb_n) ? cur : ~cur;
  initial rb_n = 1'b1;
  always @(posedge we_n) if (!ce_n) begin
    if (busy && !(cle && io inside {8'h70, 8'h71, 8'hFF})) n_ign++;
    else if (cle) begin
      last_cmd = io;
      ai = (io == 8'h60) ? 2 : 0;
      n00 += (io == 8'h00);
      if (fin && !wp_n && io inside {8'h10, 8'h15, 8'h11, 8'hD0}) lock_err = 1;
      else if (fin) begin
        progs += (io == 8'h10);
        rb_n <= 1'b0;
        // Ready lands off the clock edge, never racing the host's sample
        rb_n <= #(busy_ns + 30) 1'b1;
      end
    end else if (ale) begin
      case (ai)
        0: col[7:0] = io;
        1: col[12:8] = io[4:0];
        2: row[7:0] = io;
        3: row[15:8] = io;
        default: row[17:16] = io[1:0];
      endcase
      ai++;
    end else if (!wp_n) lock_err = 1;
    else begin
      wbuf[col] = io;
      col++;
    end
  end
  // Data lags the strobe fall, as a real die would
  always @(negedge rd_stb_n) if (!ce_n) begin
    if (busy) n_ign++;
    else begin
      cur <= #20 col[7:0] ^ row[7:0];
      col++;
    end
  end
endmodule

// ===== dv/nand_command_read_program_bench.sv
`timescale 1ns/100ps
module nand_command_read_program_bench;
  import ncr_pkg::*;
  logic        clk = 0, rst = 1, cmd_valid = 0, prog_unlock = 0, wr_valid = 0, rd_ready = 1;
  ncr_op_e     cmd_op = OP_STATUS;
  logic [12:0] cmd_col = 0, cmd_len = 0;
  logic [17:0] cmd_row = 0;
  logic [7:0]  wr_data = 0, io_out, io_in, fq, rd_data;
  logic        cmd_ready, cmd_done, cmd_err, wr_ready, rd_valid, io_oe, ready_busy_n;
  logic        command_latch_enable, address_latch_strobe, chip_select_n;
  logic        write_strobe_n, output_strobe_n, program_lock_n;
  int          num_errors = 0, n_checks = 0, cyc = 0, p;
  logic [7:0]  wq[$], rq[$];
  ////////////////////
  assign io_in = io_oe ? io_out : fq;
  ncr_host DUT (.clk, .rst, .cmd_valid, .cmd_op, .cmd_col, .cmd_row, .cmd_len, .prog_unlock,
    .cmd_ready, .cmd_done, .cmd_err, .wr_valid, .wr_data, .wr_ready, .rd_valid, .rd_data,
    .rd_ready, .command_latch_enable, .address_latch_strobe, .chip_select_n, .write_strobe_n,
    .output_strobe_n, .program_lock_n, .io_out, .io_oe, .io_in, .ready_busy_n);
  ncr_flash_model FM (.cle(command_latch_enable), .ale(address_latch_strobe),
    .ce_n(chip_select_n), .we_n(write_strobe_n), .rd_stb_n(output_strobe_n),
    .wp_n(program_lock_n), .io(io_in), .q(fq), .rb_n(ready_busy_n));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    wr_valid <= wq.size() > 0;
    wr_data  <= (wq.size() > 0) ? wq[0] : 8'h00;
    cyc      <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  // Handshakes judged at negedge, where registered outputs are settled
  always @(negedge clk) begin
    if (wr_valid && wr_ready) void'(wq.pop_front());
    if (rd_valid && rd_ready) rq.push_back(rd_data);
  end
  ////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t ns: saw %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic op(input ncr_op_e o, input logic [12:0] c, input logic [17:0] r,
                    input logic [12:0] n, input logic e);
    logic seen;
    seen = 0;
    @(posedge clk);
    cmd_valid <= 1;
    cmd_op    <= o;
    cmd_col   <= c;
    cmd_row   <= r;
    cmd_len   <= n;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 0;
    repeat (2) begin
      @(negedge clk);
      seen |= cmd_err;
    end
    chk(seen, e);
    if (!e) begin
      for (int i = 0; i < 4000 && cmd_done !== 1'b1; i++) @(negedge clk);
      chk(cmd_done, 1);
    end
  endtask
  task automatic rd_cmp(input logic [12:0] c, input logic [17:0] r, input int n);
    logic [12:0] k;
    chk(rq.size(), n);
    for (int i = 0; i < n; i++) begin
      k = c + 13'(i);
      chk(rq.pop_front(), k[7:0] ^ r[7:0]);
    end
  endtask
  ////////////////////
  task automatic s_read();
    FM.busy_ns = 3000;
    @(posedge clk);
    rd_ready <= 0;
    fork
      op(OP_READ, 13'h1FFE, 18'h2A5C3, 4, 0);
      begin
        repeat (90) @(negedge clk);
        chk(rd_valid, 1);
        chk(output_strobe_n, 1);
        @(posedge clk);
        rd_ready <= 1;
      end
    join
    rd_cmp(13'h1FFE, 18'h2A5C3, 4);
    chk(FM.row, 18'h2A5C3);
  endtask
  task automatic s_pwrup();
    p = FM.n00;
    FM.busy_ns = 200;
    op(OP_READ_PWRUP, 13'h0005, 18'h00041, 2, 0);
    chk(FM.n00, p);
    rd_cmp(13'h0005, 18'h00041, 2);
    op(OP_COL_RD, 13'h0100, 18'h00041, 3, 0);
    rd_cmp(13'h0100, 18'h00041, 3);
  endtask
  task automatic s_cache();
    op(OP_READ, 0, 18'h00080, 1, 0);
    op(OP_CACHE_RD, 0, 18'h00081, 2, 0);
    op(OP_CACHE_RD, 0, 18'h000C0, 0, 1);
    op(OP_CACHE_LAST, 0, 18'h00082, 1, 0);
    chk(FM.last_cmd, 8'h3F);
    op(OP_CACHE_RD, 0, 18'h00083, 0, 1);
    rq.delete();
  endtask
  task automatic s_lock();
    @(posedge clk);
    prog_unlock <= 0;
    repeat (3) @(negedge clk);
    chk(program_lock_n, 0);
    op(OP_PROG_LOAD, 0, 0, 0, 1);
    op(OP_ERASE, 0, 0, 0, 1);
    op(OP_PLANE_SEL, 0, 0, 0, 1);
    chk(FM.lock_err, 0);
    @(posedge clk);
    prog_unlock <= 1;
    repeat (3) @(negedge clk);
    chk(program_lock_n, 1);
  endtask
  task automatic s_prog();
    p = FM.progs;
    wq = '{8'h11, 8'h22, 8'h33};
    op(OP_PROG_LOAD, 13'h0010, 18'h00100, 3, 0);
    wq = '{8'h44, 8'h55};
    op(OP_PROG_COL, 13'h0200, 0, 2, 0);
    wq = '{8'h66};
    op(OP_PROG_COL, 13'h1FFF, 0, 1, 0);
    op(OP_CONF_PROG, 0, 0, 0, 0);
    chk(FM.progs, p + 1);
    chk(FM.row, 18'h00100);
    chk({FM.wbuf[16], FM.wbuf[17], FM.wbuf[18]}, 24'h112233);
    chk({FM.wbuf[512], FM.wbuf[513], FM.wbuf[8191]}, 24'h445566);
  endtask
  task automatic s_plane();
    op(OP_PLANE_GO, 0, 0, 0, 1);
    op(OP_PLANE_SEL, 0, 18'h00047, 0, 0);
    op(OP_PLANE_SEL, 0, 18'h000C7, 0, 1);
    op(OP_PLANE_SEL, 0, 18'h20087, 0, 1);
    op(OP_PLANE_SEL, 0, 18'h00088, 0, 1);
    op(OP_PLANE_SEL, 0, 18'h00087, 0, 0);
    op(OP_PLANE_SEL, 0, 18'h00047, 0, 1);
    op(OP_PLANE_GO, 13'h0003, 0, 2, 0);
    chk(FM.last_cmd, 8'h30);
    rq.delete();
  endtask
  task automatic s_codes();
    ncr_op_e    ops[10] = '{OP_ERASE, OP_ID, OP_STATUS, OP_STATUS_MP, OP_RESET, OP_READ_COPY,
                            OP_COPY_LOAD, OP_CONF_CACHE, OP_PLANE_LOAD, OP_CONF_PLANE};
    logic [7:0] code[10] = '{8'hD0, 8'h90, 8'h70, 8'h71, 8'hFF, 8'h3A, 8'h8C, 8'h15, 8'h81,
                             8'h11};
    foreach (ops[i]) begin
      op(ops[i], 0, 18'h00140, 0, 0);
      chk(FM.last_cmd, code[i]);
    end
  endtask
  ////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    prog_unlock <= 1;
    repeat (3) @(posedge clk);
    s_read();
    s_pwrup();
    s_cache();
    s_lock();
    s_prog();
    s_plane();
    s_codes();
    chk(FM.n_ign, 0);
    summarize();
  end
endmodule
